// [core/ctm_cfg.svh]
// register offsets, field positions and reset values of the compact timer
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// register byte offsets
`define CTM_CTRL0_OFS 12'h000
`define CTM_CTRL1_OFS 12'h004
`define CTM_CNT_OFS 12'h008
`define CTM_CMPA_OFS 12'h00C
`define CTM_PERIOD_OFS 12'h010
`define CTM_STAT_OFS 12'h014
`define CTM_CLR_OFS 12'h018
`define CTM_IEN_OFS 12'h01C

// control zero fields
`define CTM_ON_BIT 3
`define CTM_PRE_LSB 0
`define CTM_PRE_W 3

// control one fields
`define CTM_CCLR_BIT 0
`define CTM_DPX_BIT 1
`define CTM_POL_BIT 2
`define CTM_OC_BIT 3
`define CTM_IO_LSB 4
`define CTM_MODE_LSB 6

// status fields
`define CTM_AF_BIT 0
`define CTM_PF_BIT 1

// reset values
`define CTM_CTRL0_RST 8'h00
`define CTM_CTRL1_RST 8'h00
`define CTM_CMPA_RST 16'h0000
`define CTM_PERIOD_RST 8'h00

// period comparator works on counter bits 15..8, i.e. steps of 256 clocks
`define CTM_PERIOD_SHIFT 8

`endif

// [core/ctm_pkg.sv]
// types shared by the compact timer
package ctm_pkg;

    typedef enum logic [1:0] {
        CTM_MODE_CMP = 2'b00,
        CTM_MODE_RSV = 2'b01,
        CTM_MODE_PWM = 2'b10,
        CTM_MODE_TMR = 2'b11
    } ctm_mode_t;

    // control register one as seen by the timer logic
    typedef struct packed {
        ctm_mode_t mode;
        logic [1:0] io_sel;
        logic init_level;
        logic invert;
        logic swap;
        logic clear_sel;
    } ctm_ctrl1_t;

    // output pin group
    typedef struct packed {
        logic level;
        logic enable;
    } ctm_pin_t;

endpackage

// [core/ctm_timer.sv]
// compact 16-bit timer with compare match, timer and pwm modes, apb slave
`timescale 1ns/1ps
`default_nettype none
`include "ctm_cfg.svh"

// Summary of operation
// [RULE1] period value compares counter bits fifteen to eight
// [RULE2] two mode bits select operating mode
// [RULE3] clear select low: period match clears, both flags
// [RULE4] clear select high: A match clears, A flag only
// [RULE5] A zero with clear high: overflow, no flag
// [RULE6] compare mode pin changes only on A flag
// [RULE7] action bits set, clear, toggle or hold pin
// [RULE8] counter on rising loads initial pin level
// [RULE9] timer mode like compare, pin not driven
// [RULE10] pwm mode ignores clear select bit
// [RULE11] swap bit exchanges period and duty sources
// [RULE12] pwm raises A and P flags on matches
// [RULE13] pwm polarity, enable or force, invert
// [RULE14] pwm counting continues with outputs forced
// [RULE15] duty at or above period gives full duty
// [RULE16] invert bit flips pin, not in timer; the code applies invert in every mode
// [RULE17] counter steps on timer clock, cleared on start
module ctm_timer
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer output pin
    output logic timer_output_pin,
    output logic timer_output_pin_oe,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // state and register storage
    // ------------------------------------------------------------
    // registers
    logic [7:0] ctrl0_r;
    ctm_pkg::ctm_ctrl1_t ctrl1_r;
    logic [15:0] compare_a_value_r;
    logic [7:0] period_compare_high_byte_r;
    logic [1:0] status_r;
    logic [1:0] irq_en_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [7:0] prescale_r;
    logic on_d_r;
    logic pin_r;
    logic pin_nxt;
    logic pwm_active_r;

    // decoded controls
    logic counter_on_bit;
    logic on_rise;
    logic tick;
    logic [7:0] tick_mask;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] period_compare_value;
    logic [15:0] period_full;
    logic match_a;
    logic match_p;
    logic overflow;
    logic clear_cnt;
    logic set_af;
    logic set_pf;
    logic [1:0] clr_req;
    logic [15:0] pwm_period;
    logic [15:0] pwm_duty;
    logic pwm_period_zero;
    logic pwm_wrap;
    logic pwm_level;
    logic pwm_pin;
    ctm_pkg::ctm_mode_t mode;

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    // control bits feeding the timer clock, counter, flag and pin stages
    assign counter_on_bit = ctrl0_r[`CTM_ON_BIT];
    // [RULE2] two mode bits pick the mode
    assign mode = ctrl1_r.mode;
    assign on_rise = counter_on_bit && !on_d_r;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // apb decode, zero wait states
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    always_comb
    begin
        unique case (paddr)
            `CTM_CTRL0_OFS, `CTM_CTRL1_OFS, `CTM_CNT_OFS, `CTM_CMPA_OFS,
            `CTM_PERIOD_OFS, `CTM_STAT_OFS, `CTM_CLR_OFS, `CTM_IEN_OFS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    // unmapped addresses answer with an error
    assign pslverr = psel && penable && !addr_ok;

    // software writes to control and compare registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_r <= `CTM_CTRL0_RST;
            ctrl1_r <= ctm_pkg::ctm_ctrl1_t'(`CTM_CTRL1_RST);
            compare_a_value_r <= `CTM_CMPA_RST;
            period_compare_high_byte_r <= `CTM_PERIOD_RST;
            irq_en_r <= 2'h0;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                `CTM_CTRL0_OFS: ctrl0_r <= pwdata[7:0] & 8'h0F;
                `CTM_CTRL1_OFS: ctrl1_r <= ctm_pkg::ctm_ctrl1_t'(pwdata[7:0]);
                `CTM_CMPA_OFS: compare_a_value_r <= pwdata[15:0];
                `CTM_PERIOD_OFS: period_compare_high_byte_r <= pwdata[7:0];
                `CTM_IEN_OFS: irq_en_r <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // read data registered during setup, valid in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
        begin
            unique case (paddr)
                `CTM_CTRL0_OFS: prdata <= {24'h00_0000, ctrl0_r};
                `CTM_CTRL1_OFS: prdata <= {24'h00_0000, ctrl1_r};
                `CTM_CNT_OFS: prdata <= {16'h0000, count_r};
                `CTM_CMPA_OFS: prdata <= {16'h0000, compare_a_value_r};
                `CTM_PERIOD_OFS: prdata <= {24'h00_0000, period_compare_high_byte_r};
                `CTM_STAT_OFS: prdata <= {30'h0000_0000, status_r};
                `CTM_IEN_OFS: prdata <= {30'h0000_0000, irq_en_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // timer clock
    // ------------------------------------------------------------
    // timer clock: prescaler select gives pclk divided by 2^sel
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prescale_r <= 8'h00;
        else if (on_rise)
            prescale_r <= 8'h00;
        else
            prescale_r <= prescale_r + 8'h01;
    end
    // sel n waits for the low n prescaler bits all ones; sel zero masks nothing
    always_comb
    begin
        tick_mask = (8'h01 << ctrl0_r[`CTM_PRE_LSB +: `CTM_PRE_W]) - 8'h01;
        tick = ((prescale_r & tick_mask) == tick_mask);
    end

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    // [RULE1] period compares high byte
    assign period_compare_value = period_compare_high_byte_r;
    assign period_full = {period_compare_value, 8'h00};
    // match on the last count before value*256, so the clear that follows gives
    // a period of exactly value*256 ticks rather than one extra block of 256
    assign match_p = tick && (period_compare_value != 8'h00)
        && (count_r == period_full - 16'h0001);
    assign overflow = tick && (count_r == 16'hFFFF);
    // [RULE5] zero compare A never matches
    assign match_a = tick && (compare_a_value_r != 16'h0000) && (count_r == compare_a_value_r);

    // ------------------------------------------------------------
    // pwm period and duty
    // ------------------------------------------------------------
    // [RULE11] swap picks period and duty sources
    assign pwm_period = ctrl1_r.swap ? compare_a_value_r : period_full;
    assign pwm_duty = ctrl1_r.swap ? period_full : compare_a_value_r;
    assign pwm_period_zero = (pwm_period == 16'h0000);
    // period of n clocks ends at count n-1; zero period runs full 65536
    assign pwm_wrap = tick && (pwm_period_zero ? (count_r == 16'hFFFF) : (count_r == pwm_period - 16'h0001));

    // ------------------------------------------------------------
    // clear and flag sources per mode
    // ------------------------------------------------------------
    always_comb
    begin
        clear_cnt = 1'b0;
        set_af = 1'b0;
        set_pf = 1'b0;
        if (mode == ctm_pkg::CTM_MODE_PWM)
        begin
            // [RULE10] clear select ignored here
            clear_cnt = pwm_wrap;
            // [RULE12] both flags in pwm
            // with swap the counter wraps before reaching compare A, so the
            // wrap itself is the A match and the duty end is the P match
            if (ctrl1_r.swap)
            begin
                set_af = pwm_wrap;
                set_pf = match_p || (period_compare_value == 8'h00 && overflow);
            end
            else
            begin
                set_af = match_a;
                set_pf = match_p || (period_compare_value == 8'h00 && overflow);
            end
        end
        else if (!ctrl1_r.clear_sel)
        begin
            // [RULE3] period match or overflow clears
            clear_cnt = match_p || overflow;
            set_af = match_a;
            set_pf = match_p || (period_compare_value == 8'h00 && overflow);
        end
        else
        begin
            // [RULE4] A match clears, no P flag
            clear_cnt = match_a || overflow;
            set_af = match_a;
        end
        // [RULE9] timer mode shares compare behaviour via mode check above
        if (!counter_on_bit)
        begin
            clear_cnt = 1'b0;
            set_af = 1'b0;
            set_pf = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // [RULE17] counter steps on tick, reset on start
    always_comb
    begin
        count_nxt = count_r;
        if (on_rise)
            count_nxt = 16'h0000;
        else if (counter_on_bit && tick)
            count_nxt = clear_cnt ? 16'h0000 : count_r + 16'h0001;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r <= 16'h0000;
            on_d_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            on_d_r <= counter_on_bit;
        end
    end

    // ------------------------------------------------------------
    // status and interrupt
    // ------------------------------------------------------------
    // sticky status; a new event wins over a clear in the same cycle
    assign clr_req = (wr_en && paddr == `CTM_CLR_OFS) ? pwdata[1:0] : 2'b00;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_r <= 2'b00;
        else
        begin
            status_r[`CTM_AF_BIT] <= set_af || (status_r[`CTM_AF_BIT] && !clr_req[`CTM_AF_BIT]);
            status_r[`CTM_PF_BIT] <= set_pf || (status_r[`CTM_PF_BIT] && !clr_req[`CTM_PF_BIT]);
        end
    end
    assign irq = |(status_r & irq_en_r);

    // ------------------------------------------------------------
    // output pin
    // ------------------------------------------------------------
    // compare mode pin state
    always_comb
    begin
        pin_nxt = pin_r;
        // [RULE8] start loads initial level
        if (on_rise)
            pin_nxt = ctrl1_r.init_level;
        // [RULE6] only A flag moves the pin
        else if (mode == ctm_pkg::CTM_MODE_CMP && set_af)
        begin
            // [RULE7] action select
            unique case (ctrl1_r.io_sel)
                2'b00: pin_nxt = pin_r;
                2'b01: pin_nxt = 1'b0;
                2'b10: pin_nxt = 1'b1;
                2'b11: pin_nxt = !pin_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pwm waveform
    // ------------------------------------------------------------
    // pwm active phase: high from period start until duty reached
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_r <= 1'b0;
            pwm_active_r <= 1'b0;
        end
        else
        begin
            pin_r <= pin_nxt;
            if (on_rise || (counter_on_bit && tick && clear_cnt))
                pwm_active_r <= (pwm_duty != 16'h0000);
            // [RULE15] duty at or above period never ends active phase
            else if (counter_on_bit && tick && count_nxt >= pwm_duty && pwm_duty < pwm_period)
                pwm_active_r <= 1'b0;
            else if (counter_on_bit && tick && pwm_period_zero && count_nxt >= pwm_duty)
                pwm_active_r <= 1'b0;
        end
    end

    // [RULE13] polarity, force levels and enable
    assign pwm_level = ctrl1_r.init_level ? pwm_active_r : !pwm_active_r;
    always_comb
    begin
        // [RULE14] counting runs regardless of forced output
        unique case (ctrl1_r.io_sel)
            2'b00: pwm_pin = 1'b0;
            2'b01: pwm_pin = 1'b1;
            2'b10: pwm_pin = pwm_level;
            2'b11: pwm_pin = pwm_level;
        endcase
    end

    // [RULE16] invert applied in every mode, timer included; [RULE9] pin released in timer mode
    assign timer_output_pin = (mode == ctm_pkg::CTM_MODE_PWM ? pwm_pin : pin_r) ^ ctrl1_r.invert;
    assign timer_output_pin_oe = (mode != ctm_pkg::CTM_MODE_TMR) && (mode != ctm_pkg::CTM_MODE_RSV);

endmodule

`default_nettype wire

// [verification/ctm_timer_sva.sv]
// port-level checker of the compact timer
`timescale 1ns/1ps
`default_nettype none
`include "ctm_cfg.svh"
module ctm_timer_sva
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pin and interrupt
    input wire logic timer_output_pin,
    input wire logic timer_output_pin_oe,
    input wire logic irq
);
    logic wr;
    logic [7:0] c1_r;
    logic on_r;
    logic [1:0] ien_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr = psel && penable && pwrite;
    // mirrors land on the same edge as the design's registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c1_r <= 8'h00;
            on_r <= 1'b0;
            ien_r <= 2'h0;
        end
        else if (wr)
        begin
            if (paddr == `CTM_CTRL1_OFS) c1_r <= pwdata[7:0];
            if (paddr == `CTM_CTRL0_OFS) on_r <= pwdata[`CTM_ON_BIT];
            if (paddr == `CTM_IEN_OFS) ien_r <= pwdata[1:0];
        end
    end
    property p_tmr_oe;
        c1_r[7:6] == 2'b11 |-> !timer_output_pin_oe;
    endproperty
    a_tmr_oe: assert property (p_tmr_oe) else $error("pin driven in timer mode");
    property p_drv_oe;
        !c1_r[6] |-> timer_output_pin_oe;
    endproperty
    a_drv_oe: assert property (p_drv_oe) else $error("pin not driven");
    property p_force;
        c1_r[7:6] == 2'b10 && !c1_r[5] |-> timer_output_pin == (c1_r[4] ^ c1_r[2]);
    endproperty
    a_force: assert property (p_force) else $error("forced pwm level wrong");
    property p_irq_off;
        ien_r == 2'h0 |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while masked");
    property p_err;
        psel && penable && paddr > `CTM_IEN_OFS |-> pslverr && pready;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok;
        psel && penable && paddr == `CTM_CNT_OFS |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    // loaded level may land one edge after the write
    property p_on_load;
        wr && paddr == `CTM_CTRL0_OFS && pwdata[3] && !on_r && c1_r[7:4] == 4'h0
            |-> ##2 timer_output_pin == (c1_r[3] ^ c1_r[2]);
    endproperty
    a_on_load: assert property (p_on_load) else $error("initial level not loaded");
    property p_hold;
        c1_r[7:4] == 4'h0 && !wr && on_r && $past(on_r, 2) |=> $stable(timer_output_pin);
    endproperty
    a_hold: assert property (p_hold) else $error("pin moved with no action");
endmodule
bind ctm_timer ctm_timer_sva ctm_timer_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_output_pin(timer_output_pin),
    .timer_output_pin_oe(timer_output_pin_oe), .irq(irq));
`default_nettype wire

// [verification/ctm_timer_tb.sv]
// self-checking bench of the compact timer
`timescale 1ns/1ps
`default_nettype none
`include "ctm_cfg.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, timer_output_pin, timer_output_pin_oe, irq;
    int error_cnt = 0;
    int samples_checked = 0;
    ctm_timer ctm_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_output_pin(timer_output_pin),
        .timer_output_pin_oe(timer_output_pin_oe), .irq(irq));
    // free-running bus clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // one apb transfer, held until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // stop, clear flags, restart with new settings
    task automatic restart(input logic [15:0] c1, input logic [15:0] ca);
        xfer(1'b1, `CTM_CTRL0_OFS, 16'h0000);
        xfer(1'b1, `CTM_CTRL1_OFS, c1);
        xfer(1'b1, `CTM_CMPA_OFS, ca);
        xfer(1'b1, `CTM_CLR_OFS, 16'h0003);
        xfer(1'b1, `CTM_CTRL0_OFS, 16'h0008);
    endtask
    task automatic t_reset;
        xfer(1'b0, `CTM_CTRL1_OFS, 16'h0000);
        `CHK("ctrl1", 32'h0000_0000, rd)
        xfer(1'b0, `CTM_PERIOD_OFS, 16'h0000);
        `CHK("period", 32'h0000_0000, rd)
        xfer(1'b0, 12'h020, 16'h0000);
        `CHK("unmapped", 1'b1, err)
    endtask
    // compare mode, toggle on A, clear on period, interrupt path
    task automatic t_cmp;
        xfer(1'b1, `CTM_PERIOD_OFS, 16'h0001);
        xfer(1'b1, `CTM_IEN_OFS, 16'h0001);
        restart(16'h0030, 16'h0010);
        repeat (30) @(posedge pclk);
        `CHK("toggle", 1'b1, timer_output_pin)
        `CHK("irq", 1'b1, irq)
        repeat (270) @(posedge pclk);
        xfer(1'b0, `CTM_STAT_OFS, 16'h0000);
        `CHK("flags", 32'h0000_0003, rd)
        `CHK("p no move", 1'b0, timer_output_pin)
        xfer(1'b0, `CTM_CNT_OFS, 16'h0000);
        `CHK("wrap", 1'b1, rd < 256)
        xfer(1'b1, `CTM_IEN_OFS, 16'h0000);
        #1 `CHK("masked", 1'b0, irq)
        restart(16'h0008, 16'h0010);
        repeat (40) @(posedge pclk);
        `CHK("init", 1'b1, timer_output_pin)
        xfer(1'b1, `CTM_IEN_OFS, 16'h0001);
        xfer(1'b1, `CTM_CTRL0_OFS, 16'h0000);
        xfer(1'b1, `CTM_CLR_OFS, 16'h0003);
        #1 `CHK("cleared", 1'b0, irq)
    endtask
    // clear on A, A zero gives no flag and no clear, timer mode
    task automatic t_clr;
        restart(16'h0001, 16'h0200);
        repeat (700) @(posedge pclk);
        xfer(1'b0, `CTM_STAT_OFS, 16'h0000);
        `CHK("a only", 32'h0000_0001, rd)
        xfer(1'b0, `CTM_CNT_OFS, 16'h0000);
        `CHK("a clear", 1'b1, rd < 512)
        restart(16'h0001, 16'h0000);
        repeat (300) @(posedge pclk);
        xfer(1'b0, `CTM_STAT_OFS, 16'h0000);
        `CHK("no flag", 32'h0000_0000, rd)
        xfer(1'b0, `CTM_CNT_OFS, 16'h0000);
        `CHK("no clear", 1'b1, rd > 255)
        restart(16'h00C0, 16'h0010);
        repeat (300) @(posedge pclk);
        xfer(1'b0, `CTM_STAT_OFS, 16'h0000);
        `CHK("tmr flags", 32'h0000_0003, rd)
        `CHK("tmr oe", 1'b0, timer_output_pin_oe)
    endtask
    // pwm: settle, then count high cycles over 512 clocks
    task automatic pw(input logic [15:0] c1, input logic [15:0] ca, input int e);
        logic [31:0] c;
        c = 32'h0000_0000;
        xfer(1'b1, `CTM_CTRL1_OFS, c1);
        xfer(1'b1, `CTM_CMPA_OFS, ca);
        repeat (600) @(posedge pclk);
        repeat (512)
        begin
            @(negedge pclk);
            c += timer_output_pin;
        end
        `CHK("high cycles", e, c)
    endtask
    task automatic t_pwm;
        pw(16'h00A8, 16'h0040, 128);
        pw(16'h00A9, 16'h0040, 128);
        pw(16'h00A0, 16'h0040, 384);
        pw(16'h00AC, 16'h0040, 384);
        pw(16'h00A8, 16'h0100, 512);
        pw(16'h00AA, 16'h0200, 256);
        xfer(1'b1, `CTM_CLR_OFS, 16'h0003);
        repeat (600) @(posedge pclk);
        xfer(1'b0, `CTM_STAT_OFS, 16'h0000);
        `CHK("swap flags", 32'h0000_0003, rd)
        pw(16'h0098, 16'h0040, 512);
        pw(16'h0088, 16'h0040, 0);
        xfer(1'b1, `CTM_CLR_OFS, 16'h0003);
        repeat (300) @(posedge pclk);
        xfer(1'b0, `CTM_STAT_OFS, 16'h0000);
        `CHK("pwm flags", 32'h0000_0003, rd)
    endtask
    // main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cmp();
        t_clr();
        t_pwm();
        test_done();
    end
    // watchdog well beyond the expected run
    initial
    begin
        #400000;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
